// ===== inc/uotg_pkg.sv
// shared constants and types of the otg status and interrupt block
`default_nettype none
package uotg_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_LINE_SESSION_STATUS = 8'h00;
  localparam logic [7:0] OFS_EVENT_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
  localparam logic [7:0] OFS_USB_CONTROL = 8'h0C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int STAT_CABLE_BIT = 7;
  localparam int STAT_LINE_STABLE_BIT = 5;
  localparam int STAT_SESSION_VALID_BIT = 3;
  localparam int STAT_SESSION_END_BIT = 2;
  localparam int STAT_SUPPLY_VALID_BIT = 0;
  localparam int EVT_STALL_BIT = 7;
  localparam int EVT_ATTACH_BIT = 6;
  localparam int EVT_RESUME_BIT = 5;
  localparam int EVT_IDLE_BIT = 4;
  localparam int EVT_TOKEN_DONE_BIT = 3;
  localparam int EVT_FRAME_START_BIT = 2;
  localparam int EVT_ERROR_BIT = 1;
  localparam int EVT_RESET_UNPLUG_BIT = 0;
  localparam int CTRL_HOST_ROLE_BIT = 0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] EVENT_STATUS_RESET = 8'h00;
  localparam logic CONTROL_HOST_RESET = 1'b0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int LINE_STABLE_TIME_MS = 1;
  localparam int LINE_STABLE_CYCLES = LINE_STABLE_TIME_MS * CLK_FREQ_KHZ;
  localparam int STABLE_CNT_W = 17;
  typedef logic [STABLE_CNT_W-1:0] uotg_cnt_t;
  // ----------------------------------------
  // carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic stall;
    logic attach;
    logic resume;
    logic bus_idle;
    logic token_done;
    logic frame_start;
    logic error;
    logic bus_reset;
    logic unplug;
  } uotg_evt_in_t;
  typedef struct packed {
    logic cable_type_sense;
    logic se0;
    logic j_line_indication;
    logic session_valid;
    logic session_end;
    logic supply_valid;
  } uotg_pins_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_HAVE_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_HAVE_DATA = 2'h2
  } uotg_wr_state_t;
  typedef enum logic {
    RD_IDLE = 1'h0,
    RD_DATA = 1'h1
  } uotg_rd_state_t;
endpackage : uotg_pkg
`default_nettype wire

// ===== hw/uotg_status_irq.sv
// otg line and session status with usb event interrupt enables
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`default_nettype none
// Overview of operation
// - status bit 7 reads 1 with no cable or a B cable and 0 with an A cable plugged in.
// - status bit 5 reads 1 only when se0 and j-state have not changed for the last 1 ms.
// - status bit 3 reads 1 while the bus supply is above session valid in either role.
// - status bit 2 reads 1 when the bus supply is below session valid in the B role.
// - status bit 0 reads 1 when the bus supply is above the valid level in the A role.
// - bits 31 to 8 of all four registers and status bits 6, 4 and 1 always read zero.
// - enable bit 7 lets the stall event interrupt, and blocks it when clear.
// - enable bit 6 lets the attach event interrupt, and blocks it when clear.
// - enable bit 5 lets the resume event interrupt, and blocks it when clear.
// - enable bit 4 lets the bus idle event interrupt, and blocks it when clear.
// - enable bit 3 lets the token done flag interrupt, and blocks it when clear.
// - enable bit 2 lets the frame start flag interrupt, and blocks it when clear.
// - enable bit 1 must be set for an error to reach the combined interrupt flag.
// - in device role enable bit 0 gates the bus reset flag.
// - in host role enable bit 0 gates the unplug flag instead.
module uotg_status_irq #(
  parameter int unsigned LINE_STABLE_CYCLES = uotg_pkg::LINE_STABLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uotg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [uotg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uotg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [uotg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uotg_pkg::uotg_pins_t line_pins,
  input wire uotg_pkg::uotg_evt_in_t usb_events,
  output logic combined_usb_irq_flag
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // returns {hit, index}
  function automatic logic [2:0] uotg_decode(input logic [uotg_pkg::ADDR_W-1:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    case (addr)
      uotg_pkg::OFS_LINE_SESSION_STATUS: sel = 3'h4;
      uotg_pkg::OFS_EVENT_IRQ_ENABLE: sel = 3'h5;
      uotg_pkg::OFS_EVENT_STATUS: sel = 3'h6;
      uotg_pkg::OFS_USB_CONTROL: sel = 3'h7;
      default: sel = 3'h0;
    endcase
    return sel;
  endfunction : uotg_decode

  localparam logic [2:0] SEL_STATUS = 3'h4;
  localparam logic [2:0] SEL_ENABLE = 3'h5;
  localparam logic [2:0] SEL_EVENTS = 3'h6;
  localparam logic [2:0] SEL_CONTROL = 3'h7;
  localparam uotg_pkg::uotg_cnt_t STABLE_LIMIT = uotg_pkg::uotg_cnt_t'(LINE_STABLE_CYCLES);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  uotg_pkg::uotg_pins_t sync1_ff;
  uotg_pkg::uotg_pins_t sync2_ff;
  uotg_pkg::uotg_pins_t sync3_ff;
  uotg_pkg::uotg_pins_t pins_ff;
  uotg_pkg::uotg_pins_t nxt_pins;
  logic [5:0] agree;

  always_comb begin
    agree = ~(sync2_ff ^ sync3_ff);
    nxt_pins = (sync2_ff & agree) | (pins_ff & ~agree);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      pins_ff <= '0;
    end else begin
      sync1_ff <= line_pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pins_ff <= nxt_pins;
    end
  end

  // ----------------------------------------
  // line state stability timer
  // ----------------------------------------
  logic [1:0] line_prev_ff;
  logic [1:0] nxt_line_prev;
  uotg_pkg::uotg_cnt_t stable_cnt_ff;
  uotg_pkg::uotg_cnt_t nxt_stable_cnt;
  logic line_stable_flag;

  always_comb begin
    nxt_line_prev = {pins_ff.se0, pins_ff.j_line_indication};
    nxt_stable_cnt = stable_cnt_ff;
    if (nxt_line_prev != line_prev_ff) begin
      nxt_stable_cnt = '0;
    end else if (stable_cnt_ff < STABLE_LIMIT) begin
      nxt_stable_cnt = stable_cnt_ff + uotg_pkg::uotg_cnt_t'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_prev_ff <= 2'h0;
      stable_cnt_ff <= '0;
    end else begin
      line_prev_ff <= nxt_line_prev;
      stable_cnt_ff <= nxt_stable_cnt;
    end
  end

  assign line_stable_flag = (stable_cnt_ff >= STABLE_LIMIT);

  // ----------------------------------------
  // status word
  // ----------------------------------------
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[uotg_pkg::STAT_CABLE_BIT] = pins_ff.cable_type_sense;
    status_byte[uotg_pkg::STAT_LINE_STABLE_BIT] = line_stable_flag;
    status_byte[uotg_pkg::STAT_SESSION_VALID_BIT] = pins_ff.session_valid;
    status_byte[uotg_pkg::STAT_SESSION_END_BIT] = pins_ff.session_end;
    status_byte[uotg_pkg::STAT_SUPPLY_VALID_BIT] = pins_ff.supply_valid;
  end

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  uotg_pkg::uotg_wr_state_t wr_st_ff;
  uotg_pkg::uotg_wr_state_t nxt_wr_st;
  logic [uotg_pkg::ADDR_W-1:0] waddr_ff;
  logic [uotg_pkg::ADDR_W-1:0] nxt_waddr;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic wstrb_ff;
  logic nxt_wstrb;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic [2:0] wsel;
  logic [7:0] eff_data;
  logic eff_strb;

  assign s_axi_awready = (wr_st_ff == uotg_pkg::WR_IDLE) || (wr_st_ff == uotg_pkg::WR_HAVE_DATA);
  assign s_axi_wready = (wr_st_ff == uotg_pkg::WR_IDLE) || (wr_st_ff == uotg_pkg::WR_HAVE_ADDR);
  assign s_axi_bvalid = (wr_st_ff == uotg_pkg::WR_RESP);
  assign s_axi_bresp = bresp_ff;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;

  always_comb begin
    nxt_wr_st = wr_st_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bresp = bresp_ff;
    if (aw_take) begin
      nxt_waddr = s_axi_awaddr;
    end
    if (w_take) begin
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wstrb = s_axi_wstrb[0];
    end
    unique case (wr_st_ff)
      uotg_pkg::WR_IDLE: begin
        if (aw_take && w_take) begin
          nxt_wr_st = uotg_pkg::WR_RESP;
        end else if (aw_take) begin
          nxt_wr_st = uotg_pkg::WR_HAVE_ADDR;
        end else if (w_take) begin
          nxt_wr_st = uotg_pkg::WR_HAVE_DATA;
        end
      end
      uotg_pkg::WR_HAVE_ADDR: begin
        if (w_take) begin
          nxt_wr_st = uotg_pkg::WR_RESP;
        end
      end
      uotg_pkg::WR_HAVE_DATA: begin
        if (aw_take) begin
          nxt_wr_st = uotg_pkg::WR_RESP;
        end
      end
      uotg_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wr_st = uotg_pkg::WR_IDLE;
        end
      end
    endcase
    do_write = (nxt_wr_st == uotg_pkg::WR_RESP) && (wr_st_ff != uotg_pkg::WR_RESP);
    wsel = uotg_decode(nxt_waddr);
    eff_data = nxt_wdata;
    eff_strb = nxt_wstrb;
    if (do_write) begin
      nxt_bresp = wsel[2] ? uotg_pkg::RESP_OKAY : uotg_pkg::RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_ff <= uotg_pkg::WR_IDLE;
      waddr_ff <= '0;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      bresp_ff <= uotg_pkg::RESP_OKAY;
    end else begin
      wr_st_ff <= nxt_wr_st;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bresp_ff <= nxt_bresp;
    end
  end

  // ----------------------------------------
  // role select
  // ----------------------------------------
  logic host_role_ff;
  logic nxt_host_role;

  always_comb begin
    nxt_host_role = host_role_ff;
    if (do_write && eff_strb && (wsel == SEL_CONTROL)) begin
      nxt_host_role = eff_data[uotg_pkg::CTRL_HOST_ROLE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_role_ff <= uotg_pkg::CONTROL_HOST_RESET;
    end else begin
      host_role_ff <= nxt_host_role;
    end
  end

  // ----------------------------------------
  // enable and event registers
  // ----------------------------------------
  logic [7:0] irq_en_ff;
  logic [7:0] nxt_irq_en;
  logic [7:0] evt_ff;
  logic [7:0] nxt_evt;
  logic [7:0] evt_set;
  logic [7:0] evt_clr;
  logic byte0_write;

  always_comb begin
    evt_set = 8'h00;
    evt_set[uotg_pkg::EVT_STALL_BIT] = usb_events.stall;
    evt_set[uotg_pkg::EVT_ATTACH_BIT] = usb_events.attach;
    evt_set[uotg_pkg::EVT_RESUME_BIT] = usb_events.resume;
    evt_set[uotg_pkg::EVT_IDLE_BIT] = usb_events.bus_idle;
    evt_set[uotg_pkg::EVT_TOKEN_DONE_BIT] = usb_events.token_done;
    evt_set[uotg_pkg::EVT_FRAME_START_BIT] = usb_events.frame_start;
    evt_set[uotg_pkg::EVT_ERROR_BIT] = usb_events.error;
    // bit 0 source follows the role
    evt_set[uotg_pkg::EVT_RESET_UNPLUG_BIT] = host_role_ff ?
      usb_events.unplug :
      usb_events.bus_reset;
    byte0_write = do_write && eff_strb;
    nxt_irq_en = irq_en_ff;
    evt_clr = 8'h00;
    if (byte0_write && (wsel == SEL_ENABLE)) begin
      nxt_irq_en = eff_data;
    end
    if (byte0_write && (wsel == SEL_EVENTS)) begin
      evt_clr = eff_data;
    end
    // a new event beats a clear in the same cycle
    nxt_evt = (evt_ff & ~evt_clr) | evt_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_ff <= uotg_pkg::IRQ_ENABLE_RESET;
      evt_ff <= uotg_pkg::EVENT_STATUS_RESET;
    end else begin
      irq_en_ff <= nxt_irq_en;
      evt_ff <= nxt_evt;
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  logic irq_ff;
  logic nxt_irq;

  always_comb begin
    // each flag reaches the output only through its enable bit
    nxt_irq = |(evt_ff & irq_en_ff);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign combined_usb_irq_flag = irq_ff;

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  uotg_pkg::uotg_rd_state_t rd_st_ff;
  uotg_pkg::uotg_rd_state_t nxt_rd_st;
  logic [uotg_pkg::DATA_W-1:0] rdata_ff;
  logic [uotg_pkg::DATA_W-1:0] nxt_rdata;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp;
  logic [2:0] rsel;

  assign s_axi_arready = (rd_st_ff == uotg_pkg::RD_IDLE);
  assign s_axi_rvalid = (rd_st_ff == uotg_pkg::RD_DATA);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_comb begin
    nxt_rd_st = rd_st_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    rsel = uotg_decode(s_axi_araddr);
    unique case (rd_st_ff)
      uotg_pkg::RD_IDLE: begin
        if (s_axi_arvalid) begin
          nxt_rd_st = uotg_pkg::RD_DATA;
          nxt_rresp = rsel[2] ? uotg_pkg::RESP_OKAY : uotg_pkg::RESP_DECERR;
          // upper bits always read zero
          nxt_rdata = '0;
          case (rsel)
            SEL_STATUS: nxt_rdata[7:0] = status_byte;
            SEL_ENABLE: nxt_rdata[7:0] = irq_en_ff;
            SEL_EVENTS: nxt_rdata[7:0] = evt_ff;
            SEL_CONTROL: nxt_rdata[uotg_pkg::CTRL_HOST_ROLE_BIT] = host_role_ff;
            default: nxt_rdata = '0;
          endcase
        end
      end
      uotg_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          nxt_rd_st = uotg_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_ff <= uotg_pkg::RD_IDLE;
      rdata_ff <= '0;
      rresp_ff <= uotg_pkg::RESP_OKAY;
    end else begin
      rd_st_ff <= nxt_rd_st;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

endmodule : uotg_status_irq
`default_nettype wire

// ===== testbench/uotg_status_irq_props.sv
// assertion checker for the otg status and interrupt block
`default_nettype none
module uotg_status_irq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uotg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [uotg_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uotg_pkg::uotg_evt_in_t usb_events,
  input wire logic combined_usb_irq_flag
);
  // ----------------------------------------
  // read address capture
  // ----------------------------------------
  logic [uotg_pkg::ADDR_W-1:0] rd_addr_ff;
  logic [uotg_pkg::ADDR_W-1:0] nxt_rd_addr;
  always_comb begin
    nxt_rd_addr = rd_addr_ff;
    if (s_axi_arvalid && s_axi_arready) nxt_rd_addr = s_axi_araddr;
  end
  always_ff @(posedge aclk) begin
    rd_addr_ff <= nxt_rd_addr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_rd_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("rdata upper bits set");
  a_stat_unused_zero: assert property (
    s_axi_rvalid && rd_addr_ff == 8'h00 |-> s_axi_rdata[6] == 1'h0 && s_axi_rdata[4] == 1'h0
    && s_axi_rdata[1] == 1'h0) else $error("status unused bit set");
  a_rd_decerr: assert property (s_axi_rvalid && rd_addr_ff > 8'h0C |->
    s_axi_rresp == uotg_pkg::RESP_DECERR) else $error("unmapped read not refused");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held after rready");
  a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after bready");
  a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  a_irq_cause: assert property (
    $rose(combined_usb_irq_flag) |-> $past(|usb_events) || $past(|usb_events, 2)
    || s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq rose without cause");
  a_irq_fall: assert property (
    $fell(combined_usb_irq_flag) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("irq fell without write");
  a_irq_reset: assert property (
    $rose(aresetn) |-> !combined_usb_irq_flag) else $error("irq high after reset");
endmodule : uotg_status_irq_props
`default_nettype wire

// ===== testbench/uotg_usb_far.sv
// usb far side model driving line levels and event strobes
`default_nettype none
module uotg_usb_far (
  input wire logic aclk,
  output var uotg_pkg::uotg_pins_t line_pins,
  output var uotg_pkg::uotg_evt_in_t usb_events
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    line_pins = '0;
    usb_events = '0;
  end
  task automatic set_pins(input logic [5:0] p);
    line_pins <= p;
  endtask : set_pins
  task automatic pulse(input int k);
    usb_events[k] <= 1'h1;
    @(posedge aclk);
    usb_events <= '0;
  endtask : pulse
endmodule : uotg_usb_far
`default_nettype wire

// ===== testbench/uotg_status_irq_bench.sv
// self-checking bench of the otg status and interrupt block
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module uotg_status_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STABLE = 50;
  localparam logic [1:0] OKY = uotg_pkg::RESP_OKAY;
  localparam logic [1:0] DEC = uotg_pkg::RESP_DECERR;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic combined_usb_irq_flag;
  uotg_pkg::uotg_pins_t line_pins;
  uotg_pkg::uotg_evt_in_t usb_events;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  uotg_status_irq #(.LINE_STABLE_CYCLES(STABLE)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_pins, .usb_events,
    .combined_usb_irq_flag);
  uotg_usb_far far (.aclk, .line_pins, .usb_events);
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        pa = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    `CHK("bresp", er, s_axi_bresp)
  endtask : axi_wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    `CHK("rdata", ex, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask : rd_chk
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd_chk(8'h04, 32'h0, OKY);
    axi_wr(8'h04, 32'hFFFFFFFF, OKY);
    rd_chk(8'h04, 32'h000000FF, OKY);
    s_axi_wstrb <= 4'hE;
    axi_wr(8'h04, 32'h0, OKY);
    s_axi_wstrb <= 4'hF;
    rd_chk(8'h04, 32'h000000FF, OKY);
    axi_wr(8'h04, 32'h0, OKY);
    axi_wr(8'h10, 32'h1, DEC);
    rd_chk(8'h10, 32'h0, DEC);
    $display("test regs done");
  endtask : t_regs
  task automatic t_status;
    far.set_pins(6'h2D);
    repeat (STABLE + 10) @(posedge aclk);
    rd_chk(8'h00, 32'hA9, OKY);
    axi_wr(8'h00, 32'h0, OKY);
    rd_chk(8'h00, 32'hA9, OKY);
    far.set_pins(6'h02);
    repeat (8) @(posedge aclk);
    rd_chk(8'h00, 32'h04, OKY);
    $display("test status done");
  endtask : t_status
  task automatic t_irq;
    for (int i = 0; i < 8; i++) begin
      for (int m = 0; m < 2; m++) begin
        axi_wr(8'h04, m != 0 ? 32'h0 : 32'h1 << i, OKY);
        far.pulse(i + 1);
        repeat (4) @(posedge aclk);
        `CHK("irq", m == 0, combined_usb_irq_flag)
        rd_chk(8'h08, 32'h1 << i, OKY);
        axi_wr(8'h08, 32'h1 << i, OKY);
        repeat (3) @(posedge aclk);
        `CHK("irq", 1'h0, combined_usb_irq_flag)
      end
    end
    $display("test irq done");
  endtask : t_irq
  task automatic t_role;
    axi_wr(8'h0C, 32'h1, OKY);
    axi_wr(8'h04, 32'h1, OKY);
    far.pulse(1);
    repeat (4) @(posedge aclk);
    `CHK("irq", 1'h0, combined_usb_irq_flag)
    far.pulse(0);
    repeat (4) @(posedge aclk);
    `CHK("irq", 1'h1, combined_usb_irq_flag)
    axi_wr(8'h08, 32'h1, OKY);
    axi_wr(8'h0C, 32'h0, OKY);
    far.pulse(0);
    repeat (4) @(posedge aclk);
    `CHK("irq", 1'h0, combined_usb_irq_flag)
    $display("test role done");
  endtask : t_role
  task automatic t_reset;
    axi_wr(8'h04, 32'h80, OKY);
    far.pulse(8);
    repeat (4) @(posedge aclk);
    `CHK("irq", 1'h1, combined_usb_irq_flag)
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK("irq", 1'h0, combined_usb_irq_flag)
    rd_chk(8'h04, 32'h0, OKY);
    rd_chk(8'h08, 32'h0, OKY);
    $display("test reset done");
  endtask : t_reset
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  initial begin
    aresetn = 1'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_bready = 1'h1;
    s_axi_rready = 1'h1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_status();
    t_irq();
    t_role();
    t_reset();
    test_done();
  end
endmodule : uotg_status_irq_bench
bind uotg_status_irq uotg_status_irq_props props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .usb_events, .combined_usb_irq_flag);
`default_nettype wire
